// ==== inc/cbac_map.vh ====
`ifndef CBAC_MAP_VH
`define CBAC_MAP_VH
// buffer and limits
`define CBAC_BUF_POINTS 17'd100000
`define CBAC_FAST_MIN_US 20'd1
`define CBAC_STD_MIN_US 20'd1000
`define CBAC_NS_PER_US 8'd200
`define CBAC_EVENT_MAX 15'h7FFF
// curve select bit positions
`define CBAC_BIT_SENS 4
`define CBAC_BIT_EVENT 13
`define CBAC_BIT_FREQ_LO 15
`define CBAC_BIT_FREQ_HI 16
`define CBAC_BIT_SENS2 21
`define CBAC_MASK_W 22
// acquisition state codes
`define CBAC_ST_IDLE 3'h0
`define CBAC_ST_SINGLE 3'h1
`define CBAC_ST_CONT 3'h2
`define CBAC_ST_SINGLE_HALT 3'h5
`define CBAC_ST_CONT_HALT 3'h6
// command status byte bits
`define CBAC_SB_OK 8'h01
`define CBAC_SB_PARAM_ERR 8'h04
// fast and standard dump curve counts
`define CBAC_FAST_CURVES 3'h4
`define CBAC_STD_CURVES 5'h16
`endif

// ==== verilog/cbac_top.v ====
`timescale 1ns/1ps
`include "cbac_map.vh"
// Summary of operation
// - length up to 100000 fast; standard too long flags parameter error
// - clear-curves resets storage position and all status counters
// - point spacing in whole microseconds; minimum 1 fast, 1000 standard
// - single take starts at current position, stops when buffer full
// - single or edge-armed triggered start also starts linked sweep 9, 10, 11
// - triggered modes start on chosen edge or sample per edge
// - triggered stop on length, halt, or opposite external edge
// - per-point modes ignore interval; trigger under 1000 Hz
// - continuous take stops on halt, rising or falling edge by mode
// - continuous take without parameter acts as triggered mode 0
// - continuous write position wraps, overwriting oldest points
// - trigger out pulses at first point of each take or per point, chosen polarity
// - event value stored at every standard sample when bit 13 set
// - halt suspends run and linked sweep; later take resumes
// - state codes 0 idle, 1 single, 2 continuous, 5 and 6 halted
// - sweep counter counts finished curves; cleared by clear or queries
// - points counter counts stored points; cleared likewise
// - status gives state, sweeps, status byte and points
// - standard dump names a stored, selected curve bit
// - frequency dump joins lower and upper halves into one value
// - fast dump fixed point, index 0 to 3
// - 100000 points shared among standard-mode curves; frequency counts as two
// - selecting either frequency half selects both
module cbac_top #(
  parameter LEN_W = 17,
  parameter INT_W = 20,
  parameter CLK_MHZ = 200
) (
  input wire CLK_IN,
  input wire ARST_N_IN,
  input wire FAST_MODE_IN,
  input wire DUAL_MODE_IN,
  input wire [LEN_W-1:0] CURVE_LENGTH_IN,
  input wire CURVE_LENGTH_CMD_IN,
  input wire [`CBAC_MASK_W-1:0] CURVE_SELECT_MASK_IN,
  input wire CURVE_SELECT_CMD_IN,
  input wire QUERY_CLEAR_IN,
  input wire [INT_W-1:0] STORAGE_INTERVAL_IN,
  input wire STORAGE_INTERVAL_CMD_IN,
  input wire CLEAR_CURVES_CMD_IN,
  input wire SINGLE_TAKE_CMD_IN,
  input wire TRIGGERED_TAKE_CMD_IN,
  input wire [3:0] TRIGGERED_MODE_IN,
  input wire CONTINUOUS_TAKE_CMD_IN,
  input wire CONTINUOUS_HAS_PARAM_IN,
  input wire [1:0] CONTINUOUS_MODE_IN,
  input wire HALT_ACQUISITION_CMD_IN,
  input wire SWEEP_LINKED_IN,
  input wire TRIGGER_OUTPUT_TYPE_IN,
  input wire TRIGGER_OUTPUT_POLARITY_IN,
  input wire [14:0] EVENT_MARKER_IN,
  input wire EVENT_MARKER_CMD_IN,
  input wire EXTERNAL_TRIGGER_INPUT_IN,
  input wire CURVE_DUMP_CMD_IN,
  input wire [4:0] CURVE_DUMP_INDEX_IN,
  input wire [LEN_W-1:0] DUMP_POINT_IN,
  input wire [15:0] STORED_LO_IN,
  input wire [15:0] STORED_HI_IN,
  output reg [2:0] ACQ_STATE_OUT,
  output reg [15:0] SWEEP_COUNT_OUT,
  output reg [7:0] STATUS_BYTE_OUT,
  output reg [31:0] POINT_COUNT_OUT,
  output reg [LEN_W-1:0] CURVE_LENGTH_OUT,
  output reg [`CBAC_MASK_W-1:0] CURVE_SELECT_MASK_OUT,
  output reg [LEN_W-1:0] WRITE_POS_OUT,
  output reg STORE_POINT_OUT,
  output reg STORE_EVENT_OUT,
  output reg [14:0] EVENT_VALUE_OUT,
  output reg SWEEP_RUN_OUT,
  output reg TRIGGER_OUT,
  output reg DUMP_VALID_OUT,
  output reg [31:0] DUMP_DATA_OUT
);
  localparam S_IDLE = 3'd0;
  localparam S_ARM_START = 3'd1;
  localparam S_RUN = 3'd2;
  localparam S_HALT = 3'd3;
  localparam [7:0] CLK_MHZ_8 = CLK_MHZ;

  reg external_trigger_input_m_q, external_trigger_input_s_q, external_trigger_input_p_q;
  reg [2:0] state_q;
  reg cont_q, per_point_q, start_rise_q;
  reg [1:0] stop_q; // 0 length, 1 halt, 2 rising, 3 falling
  reg [INT_W-1:0] interval_q;
  reg [INT_W+7:0] tick_q;
  reg [LEN_W-1:0] taken_q;
  reg external_trigger_input_hold_q;
  reg [3:0] external_trigger_input_cnt_q;
  reg [4:0] ncurves;
  reg [LEN_W-1:0] max_len;
  integer i;

  wire rise_ev = external_trigger_input_s_q & ~external_trigger_input_p_q;
  wire fall_ev = ~external_trigger_input_s_q & external_trigger_input_p_q;
  wire [INT_W+7:0] tick_limit = interval_q * CLK_MHZ_8;
  wire interval_ev = (tick_q + 1'b1 >= tick_limit);
  wire sample_ev = per_point_q ? (start_rise_q ? rise_ev : fall_ev) : interval_ev;
  wire take_now = (state_q == S_RUN) & sample_ev;
  wire last_pt = (WRITE_POS_OUT + 1'b1 >= CURVE_LENGTH_OUT);
  wire stop_edge = (stop_q == 2'd2 & rise_ev) | (stop_q == 2'd3 & fall_ev);
  wire [`CBAC_MASK_W-1:0] mask_fix = CURVE_SELECT_MASK_IN |
    ((CURVE_SELECT_MASK_IN[`CBAC_BIT_FREQ_LO] | CURVE_SELECT_MASK_IN[`CBAC_BIT_FREQ_HI]) ?
     ((22'h1 << `CBAC_BIT_FREQ_LO) | (22'h1 << `CBAC_BIT_FREQ_HI)) : 22'h0);
  wire [INT_W-1:0] min_int = FAST_MODE_IN ? `CBAC_FAST_MIN_US : `CBAC_STD_MIN_US;

  // curves in current mask and standard length limit
  always @* begin
    ncurves = 5'd0;
    for (i = 0; i < `CBAC_MASK_W; i = i + 1)
      ncurves = ncurves + {4'd0, CURVE_SELECT_MASK_OUT[i]}; // frequency halves count two
    max_len = FAST_MODE_IN ? `CBAC_BUF_POINTS :
      ((ncurves == 5'd0) ? `CBAC_BUF_POINTS : (`CBAC_BUF_POINTS / {12'd0, ncurves}));
  end

  // trigger synchroniser and edge history
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      external_trigger_input_m_q <= 1'b0;
      external_trigger_input_s_q <= 1'b0;
      external_trigger_input_p_q <= 1'b0;
    end else begin
      external_trigger_input_m_q <= EXTERNAL_TRIGGER_INPUT_IN;
      external_trigger_input_s_q <= external_trigger_input_m_q;
      external_trigger_input_p_q <= external_trigger_input_s_q;
    end
  end

  // configuration commands and status byte
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CURVE_LENGTH_OUT <= `CBAC_BUF_POINTS;
      CURVE_SELECT_MASK_OUT <= 22'h1;
      interval_q <= `CBAC_STD_MIN_US;
      STATUS_BYTE_OUT <= 8'h00;
      EVENT_VALUE_OUT <= 15'h0000;
    end else begin
      if (CURVE_LENGTH_CMD_IN) begin
        if (CURVE_LENGTH_IN > max_len || CURVE_LENGTH_IN == {LEN_W{1'b0}})
          STATUS_BYTE_OUT <= `CBAC_SB_PARAM_ERR;
        else begin
          CURVE_LENGTH_OUT <= CURVE_LENGTH_IN;
          STATUS_BYTE_OUT <= `CBAC_SB_OK;
        end
      end else if (CURVE_SELECT_CMD_IN) begin
        CURVE_SELECT_MASK_OUT <= DUAL_MODE_IN ? mask_fix : {5'd0, mask_fix[16:0]};
        STATUS_BYTE_OUT <= `CBAC_SB_OK;
      end else if (STORAGE_INTERVAL_CMD_IN) begin
        if (STORAGE_INTERVAL_IN < min_int)
          STATUS_BYTE_OUT <= `CBAC_SB_PARAM_ERR;
        else begin
          interval_q <= STORAGE_INTERVAL_IN;
          STATUS_BYTE_OUT <= `CBAC_SB_OK;
        end
      end else if (EVENT_MARKER_CMD_IN) begin
        EVENT_VALUE_OUT <= EVENT_MARKER_IN;
        STATUS_BYTE_OUT <= `CBAC_SB_OK;
      end else if (CURVE_DUMP_CMD_IN) begin
        if (FAST_MODE_IN ? ({2'd0, CURVE_DUMP_INDEX_IN} >= {4'd0, `CBAC_FAST_CURVES}) :
            (CURVE_DUMP_INDEX_IN >= `CBAC_STD_CURVES || !CURVE_SELECT_MASK_OUT[CURVE_DUMP_INDEX_IN]))
          STATUS_BYTE_OUT <= `CBAC_SB_PARAM_ERR;
        else
          STATUS_BYTE_OUT <= `CBAC_SB_OK;
      end else if (CLEAR_CURVES_CMD_IN | SINGLE_TAKE_CMD_IN | TRIGGERED_TAKE_CMD_IN |
                   CONTINUOUS_TAKE_CMD_IN | HALT_ACQUISITION_CMD_IN) begin
        STATUS_BYTE_OUT <= `CBAC_SB_OK;
      end
    end
  end

  // acquisition sequencer
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_q <= S_IDLE;
      cont_q <= 1'b0;
      per_point_q <= 1'b0;
      start_rise_q <= 1'b1;
      stop_q <= 2'd0;
      tick_q <= {(INT_W+8){1'b0}};
      WRITE_POS_OUT <= {LEN_W{1'b0}};
      taken_q <= {LEN_W{1'b0}};
      ACQ_STATE_OUT <= `CBAC_ST_IDLE;
      SWEEP_RUN_OUT <= 1'b0;
    end else begin
      tick_q <= (state_q == S_RUN && !interval_ev) ? tick_q + 1'b1 : {(INT_W+8){1'b0}};
      if (CLEAR_CURVES_CMD_IN) begin
        state_q <= S_IDLE;
        WRITE_POS_OUT <= {LEN_W{1'b0}};
        taken_q <= {LEN_W{1'b0}};
        ACQ_STATE_OUT <= `CBAC_ST_IDLE;
        SWEEP_RUN_OUT <= 1'b0;
      end else if (HALT_ACQUISITION_CMD_IN && (state_q == S_RUN || state_q == S_ARM_START)) begin
        state_q <= S_HALT;
        SWEEP_RUN_OUT <= 1'b0;
        ACQ_STATE_OUT <= cont_q ? `CBAC_ST_CONT_HALT : `CBAC_ST_SINGLE_HALT;
      end else if (SINGLE_TAKE_CMD_IN) begin
        state_q <= S_RUN;
        taken_q <= {LEN_W{1'b0}}; // fresh curve start
        cont_q <= 1'b0;
        per_point_q <= 1'b0;
        stop_q <= 2'd0;
        ACQ_STATE_OUT <= `CBAC_ST_SINGLE;
        SWEEP_RUN_OUT <= SWEEP_LINKED_IN;
      end else if (TRIGGERED_TAKE_CMD_IN || (CONTINUOUS_TAKE_CMD_IN && !CONTINUOUS_HAS_PARAM_IN)) begin
        // mode 0 when continuous arrives bare
        cont_q <= 1'b0;
        taken_q <= {LEN_W{1'b0}};
        per_point_q <= CONTINUOUS_TAKE_CMD_IN ? 1'b0 : (TRIGGERED_MODE_IN < 4'd8 && TRIGGERED_MODE_IN[0]);
        start_rise_q <= CONTINUOUS_TAKE_CMD_IN ? 1'b1 :
          (TRIGGERED_MODE_IN == 4'd9 ? 1'b0 : (TRIGGERED_MODE_IN == 4'd8 ? 1'b1 : !TRIGGERED_MODE_IN[1]));
        stop_q <= CONTINUOUS_TAKE_CMD_IN ? 2'd0 :
          (TRIGGERED_MODE_IN == 4'd8 ? 2'd3 : (TRIGGERED_MODE_IN == 4'd9 ? 2'd2 :
          (TRIGGERED_MODE_IN[2] ? 2'd1 : 2'd0)));
        state_q <= (!CONTINUOUS_TAKE_CMD_IN && TRIGGERED_MODE_IN < 4'd8 && TRIGGERED_MODE_IN[0]) ?
          S_RUN : S_ARM_START;
        ACQ_STATE_OUT <= `CBAC_ST_SINGLE;
        SWEEP_RUN_OUT <= 1'b0;
      end else if (CONTINUOUS_TAKE_CMD_IN) begin
        state_q <= S_RUN;
        taken_q <= {LEN_W{1'b0}};
        cont_q <= 1'b1;
        per_point_q <= 1'b0;
        stop_q <= (CONTINUOUS_MODE_IN == 2'd1) ? 2'd2 : ((CONTINUOUS_MODE_IN == 2'd2) ? 2'd3 : 2'd1);
        ACQ_STATE_OUT <= `CBAC_ST_CONT;
      end else begin
        case (state_q)
          S_ARM_START: begin
            if (start_rise_q ? rise_ev : fall_ev) begin
              state_q <= S_RUN;
              SWEEP_RUN_OUT <= SWEEP_LINKED_IN;
            end
          end
          S_RUN: begin
            if (stop_edge) begin
              state_q <= S_IDLE;
              ACQ_STATE_OUT <= `CBAC_ST_IDLE;
              SWEEP_RUN_OUT <= 1'b0;
            end else if (take_now) begin
              taken_q <= taken_q + 1'b1;
              WRITE_POS_OUT <= last_pt ? {LEN_W{1'b0}} : WRITE_POS_OUT + 1'b1;
              if (last_pt && !cont_q && stop_q == 2'd0) begin
                state_q <= S_IDLE;
                ACQ_STATE_OUT <= `CBAC_ST_IDLE;
                SWEEP_RUN_OUT <= 1'b0;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // counters, store strobes, trigger output and dump joining
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SWEEP_COUNT_OUT <= 16'h0000;
      POINT_COUNT_OUT <= 32'h0000_0000;
      STORE_POINT_OUT <= 1'b0;
      STORE_EVENT_OUT <= 1'b0;
      external_trigger_input_hold_q <= 1'b0;
      external_trigger_input_cnt_q <= 4'h0;
      TRIGGER_OUT <= 1'b0;
      DUMP_VALID_OUT <= 1'b0;
      DUMP_DATA_OUT <= 32'h0000_0000;
    end else begin
      STORE_POINT_OUT <= take_now & ~stop_edge & ~CLEAR_CURVES_CMD_IN;
      STORE_EVENT_OUT <= take_now & ~stop_edge & ~FAST_MODE_IN &
        CURVE_SELECT_MASK_OUT[`CBAC_BIT_EVENT];
      if (CLEAR_CURVES_CMD_IN || QUERY_CLEAR_IN) begin
        SWEEP_COUNT_OUT <= 16'h0000;
        POINT_COUNT_OUT <= 32'h0000_0000;
      end else if (take_now && !stop_edge) begin
        POINT_COUNT_OUT <= POINT_COUNT_OUT + 1'b1;
        if (last_pt)
          SWEEP_COUNT_OUT <= SWEEP_COUNT_OUT + 1'b1;
      end
      // pulse stretched to 16 cycles, polarity selects active edge
      if ((take_now && !stop_edge && (TRIGGER_OUTPUT_TYPE_IN || taken_q == {LEN_W{1'b0}}))) begin
        external_trigger_input_hold_q <= 1'b1;
        external_trigger_input_cnt_q <= 4'hF;
      end else if (external_trigger_input_cnt_q != 4'h0)
        external_trigger_input_cnt_q <= external_trigger_input_cnt_q - 1'b1;
      else
        external_trigger_input_hold_q <= 1'b0;
      TRIGGER_OUT <= external_trigger_input_hold_q ^ TRIGGER_OUTPUT_POLARITY_IN;
      DUMP_VALID_OUT <= CURVE_DUMP_CMD_IN;
      if (CURVE_DUMP_CMD_IN)
        DUMP_DATA_OUT <= (!FAST_MODE_IN && CURVE_DUMP_INDEX_IN == `CBAC_BIT_FREQ_LO) ?
          {STORED_HI_IN, STORED_LO_IN} : {{16{STORED_LO_IN[15]}}, STORED_LO_IN};
    end
  end
endmodule // cbac_top

// ==== bench/cbac_ext_external_trigger_input.sv ====
`timescale 1ns/1ps
module cbac_ext_external_trigger_input #(parameter DLY = 7) (
  input wire level_in,
  output reg external_trigger_input_out
);
  // pin follows the asked level after a skew unrelated to the clock
  initial external_trigger_input_out = 1'b0;
  always @(level_in) external_trigger_input_out <= #DLY level_in;
endmodule // cbac_ext_external_trigger_input

// ==== bench/cbac_properties.sv ====
`timescale 1ns/1ps
module cbac_properties (
  input wire CLK_IN, input wire ARST_N_IN, input wire [16:0] CURVE_LENGTH_IN, input wire CURVE_LENGTH_CMD_IN,
  input wire CLEAR_CURVES_CMD_IN, input wire SINGLE_TAKE_CMD_IN, input wire CONTINUOUS_TAKE_CMD_IN,
  input wire CONTINUOUS_HAS_PARAM_IN, input wire HALT_ACQUISITION_CMD_IN, input wire QUERY_CLEAR_IN,
  input wire [2:0] ACQ_STATE_OUT, input wire [15:0] SWEEP_COUNT_OUT, input wire [7:0] STATUS_BYTE_OUT,
  input wire [31:0] POINT_COUNT_OUT, input wire [16:0] CURVE_LENGTH_OUT, input wire [21:0] CURVE_SELECT_MASK_OUT,
  input wire STORE_POINT_OUT, input wire SWEEP_RUN_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // suspended single run with its sweep stopped
  sequence s_single_halted;
    ACQ_STATE_OUT == 3'h5 && !SWEEP_RUN_OUT;
  endsequence
  chk_single_start: assert property (SINGLE_TAKE_CMD_IN && !CLEAR_CURVES_CMD_IN && !HALT_ACQUISITION_CMD_IN
    |=> ACQ_STATE_OUT == 3'h1) else $error("single not run");
  chk_cont_start: assert property (CONTINUOUS_TAKE_CMD_IN && CONTINUOUS_HAS_PARAM_IN && !CLEAR_CURVES_CMD_IN
    |=> ACQ_STATE_OUT == 3'h2) else $error("cont not run");
  chk_halt_single: assert property (HALT_ACQUISITION_CMD_IN && !CLEAR_CURVES_CMD_IN && ACQ_STATE_OUT == 3'h1
    |=> s_single_halted) else $error("halt missed");
  chk_clear_all: assert property (CLEAR_CURVES_CMD_IN |=> ACQ_STATE_OUT == 3'h0 && SWEEP_COUNT_OUT == 16'h0
    && POINT_COUNT_OUT == 32'h0) else $error("clear missed");
  chk_query_zero: assert property (QUERY_CLEAR_IN && ACQ_STATE_OUT != 3'h1 && ACQ_STATE_OUT != 3'h2
    |=> SWEEP_COUNT_OUT == 16'h0 && POINT_COUNT_OUT == 32'h0) else $error("query kept counts");
  chk_point_step: assert property (STORE_POINT_OUT && !$past(QUERY_CLEAR_IN) |->
    POINT_COUNT_OUT == $past(POINT_COUNT_OUT) + 32'h1)
    else $error("bad point step");
  chk_len_refuse: assert property (CURVE_LENGTH_CMD_IN && CURVE_LENGTH_IN == 17'h0
    |=> STATUS_BYTE_OUT == 8'h04 && $stable(CURVE_LENGTH_OUT)) else $error("zero length taken");
  chk_freq_pair: assert property (CURVE_SELECT_MASK_OUT[15] == CURVE_SELECT_MASK_OUT[16])
    else $error("freq unpaired");
endmodule // cbac_properties
bind cbac_top cbac_properties cbac_properties_inst (.CLK_IN, .ARST_N_IN, .CURVE_LENGTH_IN, .CURVE_LENGTH_CMD_IN,
  .CLEAR_CURVES_CMD_IN, .SINGLE_TAKE_CMD_IN, .CONTINUOUS_TAKE_CMD_IN, .CONTINUOUS_HAS_PARAM_IN,
  .HALT_ACQUISITION_CMD_IN, .QUERY_CLEAR_IN, .ACQ_STATE_OUT, .SWEEP_COUNT_OUT, .STATUS_BYTE_OUT, .POINT_COUNT_OUT,
  .CURVE_LENGTH_OUT, .CURVE_SELECT_MASK_OUT, .STORE_POINT_OUT, .SWEEP_RUN_OUT);

// ==== bench/tb_cbac_top.sv ====
`timescale 1ns/1ps
module tb_cbac_top;
  reg clk, rst_n, fast, hp, lnk, tty, ext;
  reg [10:0] cv;
  reg [16:0] lin;
  reg [21:0] sin;
  reg [19:0] iin;
  reg [1:0] cm;
  reg [4:0] dix;
  wire [2:0] acq;
  wire [15:0] swc;
  wire [7:0] sb;
  wire [31:0] ptc;
  wire [16:0] len_o, wp;
  wire [21:0] msk;
  wire st_pt, sw, external_trigger_input, trg;
  wire [14:0] ev;
  wire [31:0] dd;
  integer failures, n_tests, ncyc;
  // block and external trigger source
  cbac_top cbac_top_inst (.CLK_IN(clk), .ARST_N_IN(rst_n), .FAST_MODE_IN(fast), .DUAL_MODE_IN(1'b0),
    .CURVE_LENGTH_IN(lin), .CURVE_LENGTH_CMD_IN(cv[0]), .CURVE_SELECT_MASK_IN(sin), .CURVE_SELECT_CMD_IN(cv[1]),
    .QUERY_CLEAR_IN(cv[2]), .STORAGE_INTERVAL_IN(iin), .STORAGE_INTERVAL_CMD_IN(cv[3]), .CLEAR_CURVES_CMD_IN(cv[4]),
    .SINGLE_TAKE_CMD_IN(cv[5]), .TRIGGERED_TAKE_CMD_IN(cv[6]), .TRIGGERED_MODE_IN(4'h0),
    .CONTINUOUS_TAKE_CMD_IN(cv[7]), .CONTINUOUS_HAS_PARAM_IN(hp), .CONTINUOUS_MODE_IN(cm),
    .HALT_ACQUISITION_CMD_IN(cv[8]), .SWEEP_LINKED_IN(lnk), .TRIGGER_OUTPUT_TYPE_IN(tty),
    .TRIGGER_OUTPUT_POLARITY_IN(1'b0), .EVENT_MARKER_IN(15'h7FFF), .EVENT_MARKER_CMD_IN(cv[10]),
    .EXTERNAL_TRIGGER_INPUT_IN(external_trigger_input), .CURVE_DUMP_CMD_IN(cv[9]), .CURVE_DUMP_INDEX_IN(dix), .DUMP_POINT_IN(17'h0),
    .STORED_LO_IN(ncyc[15:0]), .STORED_HI_IN(ncyc[31:16]), .ACQ_STATE_OUT(acq), .SWEEP_COUNT_OUT(swc),
    .STATUS_BYTE_OUT(sb), .POINT_COUNT_OUT(ptc), .CURVE_LENGTH_OUT(len_o), .CURVE_SELECT_MASK_OUT(msk),
    .WRITE_POS_OUT(wp), .STORE_POINT_OUT(st_pt), .STORE_EVENT_OUT(), .EVENT_VALUE_OUT(ev), .SWEEP_RUN_OUT(sw),
    .TRIGGER_OUT(trg), .DUMP_VALID_OUT(), .DUMP_DATA_OUT(dd));
  cbac_ext_external_trigger_input cbac_ext_external_trigger_input_inst (.level_in(ext), .external_trigger_input_out(external_trigger_input));
  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) ncyc <= ncyc + 1;
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one command pulse, then one idle cycle
  task cmd(input integer c);
    cv = 11'h001 << c;
    cyc(1);
    cv = 11'h000;
    cyc(1);
  endtask
  // wait for n stored points, bounded
  task wpts(input integer n);
    integer k;
    k = 0;
    repeat (20000) if (k < n) begin
      cyc(1);
      k = k + st_pt;
    end
  endtask
  task t_cfg;
    chk("len rst", 17'h186A0, len_o);
    cmd(0);
    sin = 22'h008001;
    cmd(1);
    chk("pair", 22'h018001, msk);
    lin = 17'h8236;
    cmd(0);
    chk("len std", 8'h04, sb);
    iin = 20'h3E7;
    cmd(3);
    chk("int std", 8'h04, sb);
    dix = 5'hF;
    cmd(9);
    chk("freq dump", ncyc - 2, dd);
    chk("dump sel", 8'h01, sb);
    cmd(10);
    chk("event", 15'h7FFF, ev);
    {fast, lin, iin} = {1'b1, 17'h4, 20'h1};
    cmd(0);
    chk("len ok", 17'h4, len_o);
    cmd(3);
    chk("int min", 8'h01, sb);
  endtask
  task t_single;
    integer t0;
    lnk = 1'b1;
    cmd(5);
    chk("sweep", 1'b1, sw);
    wpts(1);
    t0 = ncyc;
    wpts(1);
    chk("gap", 32'hC8, ncyc - t0);
    wpts(2);
    cyc(1);
    chk("done", 3'h0, acq);
    chk("sweeps", 16'h1, swc);
  endtask
  task t_halt;
    cmd(4);
    chk("pos clr", 17'h0, wp);
    cmd(5);
    wpts(1);
    cmd(8);
    cyc(400);
    chk("held", 32'h1, ptc);
    cmd(5);
    wpts(3);
    cyc(1);
    chk("resumed", 32'h4, ptc);
  endtask
  task t_external_trigger_input;
    cmd(4);
    cmd(6);
    cyc(400);
    chk("armed", 32'h0, ptc);
    ext = 1'b1;
    wpts(4);
    cyc(1);
    chk("external_trigger_input end", 3'h0, acq);
    dix = 5'h4;
    cmd(9);
    chk("fast idx", 8'h04, sb);
  endtask
  task t_cont;
    cmd(4);
    {hp, tty} = 2'b11;
    cmd(7);
    wpts(5);
    chk("wrap", 17'h1, wp);
    chk("cycles", 16'h1, swc);
    cyc(1);
    chk("external_trigger_input out", 1'b1, trg);
    cmd(8);
    chk("cont halt", 3'h6, acq);
    cmd(2);
    chk("query sweeps", 16'h0, swc);
    chk("query points", 32'h0, ptc);
  endtask
  task end_sim;
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // reset then scenarios
  initial begin
    {rst_n, fast, hp, lnk, tty, ext, cv, lin, sin, iin, cm, dix} = '0;
    {failures, n_tests, ncyc} = '0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_cfg;
    t_single;
    t_halt;
    t_external_trigger_input;
    t_cont;
    end_sim;
  end
  // watchdog
  initial begin
    #300000;
    failures = failures + 1;
    end_sim;
  end
endmodule // tb_cbac_top
